//--- hdl/afe_defines.svh
`ifndef AFE_DEFINES_SVH
`define AFE_DEFINES_SVH

// Device register addresses on the link.
`define AFE_A_CFG       3'h0
`define AFE_A_MUX       3'h1
`define AFE_A_GAIN_R    3'h2
`define AFE_A_GAIN_G    3'h3
`define AFE_A_GAIN_B    3'h4
`define AFE_A_OFFS_R    3'h5
`define AFE_A_OFFS_G    3'h6
`define AFE_A_OFFS_B    3'h7

// Configuration field positions.
`define AFE_CFG_RANGE   7
`define AFE_CFG_VREF    6
`define AFE_CFG_3CH     5
`define AFE_CFG_DSM     4
`define AFE_CFG_CLAMP   3
`define AFE_CFG_SLEEP   2

// Channel order field positions.
`define AFE_MUX_DIR     7
`define AFE_MUX_RED     6
`define AFE_MUX_GREEN   5
`define AFE_MUX_BLUE    4

// Writable bit masks; the other bits are kept at zero.
`define AFE_CFG_MASK    9'h0fc
`define AFE_MUX_MASK    9'h0f0
`define AFE_GAIN_MASK   9'h03f
`define AFE_OFFS_MASK   9'h1ff

// Reset values.
`define AFE_CFG_RST     9'h0f8
`define AFE_MUX_RST     9'h0c0
`define AFE_GAIN_RST    9'h000
`define AFE_OFFS_RST    9'h000

// Controller APB register byte addresses.
`define AFE_H_CMD       12'h000
`define AFE_H_STATUS    12'h004
`define AFE_H_RUN       12'h008

// Controller command and status field positions.
`define AFE_CMD_ADDR_LO 12
`define AFE_CMD_READ    16
`define AFE_ST_BUSY     0
`define AFE_ST_DONE     1
`define AFE_ST_DATA_LO  16

// Default converter clock period in core clock cycles.
`define AFE_CONV_DIV    8

`endif

//--- hdl/afe_pkg.sv
`default_nettype none
package afe_pkg;
    typedef logic [8:0] afe_word_t;
    typedef enum logic [1:0] {
        CH_RED,
        CH_GREEN,
        CH_BLUE
    } afe_chan_e;
    typedef enum logic [1:0] {
        H_IDLE,
        H_REQ,
        H_WAIT
    } afe_hstate_e;
endpackage
`default_nettype wire

//--- hdl/afe_link_if.sv
`default_nettype none
interface afe_link_if;
    logic             req;
    logic             we;
    logic [2:0]       addr;
    afe_pkg::afe_word_t wdata;
    logic             ack;
    afe_pkg::afe_word_t rdata;
    logic             data_sample_clock;
    logic             converter_clock;

    modport dev (
        input  req, we, addr, wdata, data_sample_clock, converter_clock,
        output ack, rdata
    );
    modport host (
        output req, we, addr, wdata, data_sample_clock, converter_clock,
        input  ack, rdata
    );
endinterface
`default_nettype wire

//--- hdl/afe_dev.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`include "afe_defines.svh"
`default_nettype none
module afe_dev (
    // Clock and reset.
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // Link to the controller.
    afe_link_if.dev                  link,
    // Operating mode outputs.
    output var  logic                full_scale_4v,
    output var  logic                int_ref_en,
    output var  logic                channel_count_select,
    output var  logic                double_sampling_mode,
    output var  logic                clamp_4v,
    output var  logic                sleep_select,
    // Active channel and its analog settings.
    output var  afe_pkg::afe_chan_e  active_channel,
    output var  logic [5:0]          gain_amplifier,
    output var  logic [7:0]          offset_mag,
    output var  logic                offset_neg
);
    afe_pkg::afe_word_t cfg_q;
    afe_pkg::afe_word_t mux_q;
    afe_pkg::afe_word_t gain_q [3];
    afe_pkg::afe_word_t offs_q [3];
    afe_pkg::afe_chan_e ch_q;
    afe_pkg::afe_chan_e ch_d;
    afe_pkg::afe_chan_e first_ch;
    afe_pkg::afe_chan_e single_ch;
    afe_pkg::afe_word_t rd_word;
    logic               conv_prev_q;
    logic               conv_fall;
    logic               wr;

    assign wr = link.req && link.we;

    // Configuration register; sleep does not touch any register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= `AFE_CFG_RST;
        end else if (wr && link.addr == `AFE_A_CFG) begin
            cfg_q <= link.wdata & `AFE_CFG_MASK;
        end
    end

    // Channel order register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_q <= `AFE_MUX_RST;
        end else if (wr && link.addr == `AFE_A_MUX) begin
            mux_q <= link.wdata & `AFE_MUX_MASK;
        end
    end

    // Per channel gain and offset registers, each decoded on its own address.
    for (genvar i = 0; i < 3; i++) begin : g_chan
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                gain_q[i] <= `AFE_GAIN_RST;
                offs_q[i] <= `AFE_OFFS_RST;
            end else if (wr) begin
                if (link.addr == `AFE_A_GAIN_R + 3'(i)) begin
                    gain_q[i] <= link.wdata & `AFE_GAIN_MASK;
                end
                if (link.addr == `AFE_A_OFFS_R + 3'(i)) begin
                    offs_q[i] <= link.wdata & `AFE_OFFS_MASK;
                end
            end
        end
    end

    // Read mux for the link.
    always_comb begin
        case (link.addr)
            `AFE_A_CFG:    rd_word = cfg_q;
            `AFE_A_MUX:    rd_word = mux_q;
            `AFE_A_GAIN_R: rd_word = gain_q[0];
            `AFE_A_GAIN_G: rd_word = gain_q[1];
            `AFE_A_GAIN_B: rd_word = gain_q[2];
            `AFE_A_OFFS_R: rd_word = offs_q[0];
            `AFE_A_OFFS_G: rd_word = offs_q[1];
            default:       rd_word = offs_q[2];
        endcase
    end

    // Every request is answered one cycle later; reads return the word.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.ack   <= 1'b0;
            link.rdata <= 9'h000;
        end else begin
            link.ack <= link.req;
            if (link.req && !link.we) begin
                link.rdata <= rd_word;
            end
        end
    end

    // Falling edge detector on the converter clock.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_prev_q <= 1'b0;
        end else begin
            conv_prev_q <= link.converter_clock;
        end
    end
    assign conv_fall = conv_prev_q && !link.converter_clock;

    // First channel of a sequence and the fixed single channel choice.
    always_comb begin
        first_ch = mux_q[`AFE_MUX_DIR] ? afe_pkg::CH_RED : afe_pkg::CH_BLUE;
        if (mux_q[`AFE_MUX_RED]) begin
            single_ch = afe_pkg::CH_RED;
        end else if (mux_q[`AFE_MUX_GREEN]) begin
            single_ch = afe_pkg::CH_GREEN;
        end else if (mux_q[`AFE_MUX_BLUE]) begin
            single_ch = afe_pkg::CH_BLUE;
        end else begin
            single_ch = afe_pkg::CH_RED;
        end
    end

    // Next multiplexer position.
    always_comb begin
        ch_d = ch_q;
        if (!cfg_q[`AFE_CFG_3CH]) begin
            ch_d = single_ch;
        end else if (cfg_q[`AFE_CFG_SLEEP]) begin
            ch_d = ch_q;
        end else if (link.data_sample_clock) begin
            ch_d = first_ch;
        end else if (conv_fall) begin
            case (ch_q)
                afe_pkg::CH_RED:   ch_d = mux_q[`AFE_MUX_DIR] ? afe_pkg::CH_GREEN
                                                             : first_ch;
                afe_pkg::CH_GREEN: ch_d = mux_q[`AFE_MUX_DIR] ? afe_pkg::CH_BLUE
                                                             : afe_pkg::CH_RED;
                afe_pkg::CH_BLUE:  ch_d = mux_q[`AFE_MUX_DIR] ? first_ch
                                                             : afe_pkg::CH_GREEN;
                default:           ch_d = first_ch;
            endcase
        end
    end

    // Multiplexer position register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_q <= afe_pkg::CH_RED;
        end else begin
            ch_q <= ch_d;
        end
    end

    // Mode outputs decoded from the configuration register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            full_scale_4v        <= 1'b1;
            int_ref_en           <= 1'b1;
            channel_count_select <= 1'b1;
            double_sampling_mode <= 1'b1;
            clamp_4v             <= 1'b1;
            sleep_select         <= 1'b0;
        end else begin
            full_scale_4v        <= cfg_q[`AFE_CFG_RANGE];
            int_ref_en           <= cfg_q[`AFE_CFG_VREF];
            channel_count_select <= cfg_q[`AFE_CFG_3CH];
            double_sampling_mode <= cfg_q[`AFE_CFG_DSM];
            clamp_4v             <= cfg_q[`AFE_CFG_CLAMP];
            sleep_select         <= cfg_q[`AFE_CFG_SLEEP];
        end
    end

    // Settings of the active channel, one cycle behind the position.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_channel <= afe_pkg::CH_RED;
            gain_amplifier <= 6'h00;
            offset_mag     <= 8'h00;
            offset_neg     <= 1'b0;
        end else begin
            active_channel <= ch_q;
            gain_amplifier <= gain_q[ch_q][5:0];
            offset_mag     <= offs_q[ch_q][7:0];
            offset_neg     <= offs_q[ch_q][8] && (offs_q[ch_q][7:0] != 8'h00);
        end
    end
endmodule
`default_nettype wire

//--- hdl/afe_host.sv
`include "afe_defines.svh"
`default_nettype none
module afe_host #(
    parameter int CONV_DIV = `AFE_CONV_DIV
) (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Link to the device.
    afe_link_if.host         link
);
    afe_pkg::afe_hstate_e st_q;
    logic                 done_q;
    afe_pkg::afe_word_t   rdata_q;
    logic                 run_q;
    logic [7:0]           div_q;
    logic [1:0]           step_q;
    logic                 setup;
    logic                 acc;
    logic                 wr_cmd;
    logic                 mapped;
    logic [31:0]          rd_mux;
    afe_pkg::afe_word_t   mask;

    assign setup  = psel && !penable;
    assign acc    = psel && penable && pready;
    assign wr_cmd = acc && pwrite && paddr == `AFE_H_CMD && st_q == afe_pkg::H_IDLE;
    assign mapped = paddr == `AFE_H_CMD || paddr == `AFE_H_STATUS || paddr == `AFE_H_RUN;

    // Reserved device bits are forced to zero before they go out.
    always_comb begin
        case (pwdata[`AFE_CMD_ADDR_LO +: 3])
            `AFE_A_CFG:    mask = `AFE_CFG_MASK;
            `AFE_A_MUX:    mask = `AFE_MUX_MASK;
            `AFE_A_GAIN_R,
            `AFE_A_GAIN_G,
            `AFE_A_GAIN_B: mask = `AFE_GAIN_MASK;
            default:       mask = `AFE_OFFS_MASK;
        endcase
    end

    // APB read data.
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == `AFE_H_STATUS) begin
            rd_mux[`AFE_ST_BUSY] = st_q != afe_pkg::H_IDLE;
            rd_mux[`AFE_ST_DONE] = done_q;
            rd_mux[`AFE_ST_DATA_LO +: 9] = rdata_q;
        end else if (paddr == `AFE_H_RUN) begin
            rd_mux[0] = run_q;
        end
    end

    // APB answer: one wait-free access phase after every setup cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                prdata <= rd_mux;
            end
        end
    end

    // Link transfer sequencer; the device is reached only through it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= afe_pkg::H_IDLE;
            link.req   <= 1'b0;
            link.we    <= 1'b0;
            link.addr  <= 3'h0;
            link.wdata <= 9'h000;
        end else begin
            case (st_q)
                afe_pkg::H_IDLE: begin
                    if (wr_cmd) begin
                        st_q       <= afe_pkg::H_REQ;
                        link.req   <= 1'b1;
                        link.we    <= !pwdata[`AFE_CMD_READ];
                        link.addr  <= pwdata[`AFE_CMD_ADDR_LO +: 3];
                        link.wdata <= pwdata[8:0] & mask;
                    end
                end
                afe_pkg::H_REQ: begin
                    link.req <= 1'b0;
                    st_q     <= afe_pkg::H_WAIT;
                end
                afe_pkg::H_WAIT: begin
                    if (link.ack) begin
                        st_q <= afe_pkg::H_IDLE;
                    end
                end
                default: st_q <= afe_pkg::H_IDLE;
            endcase
        end
    end

    // Done flag and read result; completion wins over a clear.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q  <= 1'b0;
            rdata_q <= 9'h000;
        end else if (st_q == afe_pkg::H_WAIT && link.ack) begin
            done_q <= 1'b1;
            if (!link.we) begin
                rdata_q <= link.rdata;
            end
        end else if (acc && pwrite && paddr == `AFE_H_STATUS && pwdata[`AFE_ST_DONE]) begin
            done_q <= 1'b0;
        end
    end

    // Run control.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (acc && pwrite && paddr == `AFE_H_RUN) begin
            run_q <= pwdata[0];
        end
    end

    // Sampling clocks: converter clock of CONV_DIV cycles, a sample pulse every three.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q                  <= 8'h00;
            step_q                 <= 2'h0;
            link.converter_clock   <= 1'b0;
            link.data_sample_clock <= 1'b0;
        end else if (!run_q) begin
            div_q                  <= 8'h00;
            step_q                 <= 2'h0;
            link.converter_clock   <= 1'b0;
            link.data_sample_clock <= 1'b0;
        end else begin
            link.data_sample_clock <= 1'b0;
            if (div_q == 8'(CONV_DIV - 1)) begin
                div_q <= 8'h00;
                step_q <= (step_q == 2'h2) ? 2'h0 : step_q + 2'h1;
                link.data_sample_clock <= step_q == 2'h2;
            end else begin
                div_q <= div_q + 8'h01;
            end
            link.converter_clock <= div_q < 8'(CONV_DIV / 2);
        end
    end
endmodule
`default_nettype wire

//--- verification/afe_link_chk.sv
`include "afe_defines.svh"
`default_nettype none
module afe_link_chk (
    // Clock and reset.
    input wire logic               core_clk,
    input wire logic               rst_n,
    // Link signals.
    input wire logic               req,
    input wire logic               we,
    input wire logic [2:0]         addr,
    input wire afe_pkg::afe_word_t wdata,
    input wire logic               ack,
    input wire afe_pkg::afe_word_t rdata,
    input wire logic               data_sample_clock,
    input wire logic               converter_clock
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // One request and the answer that follows it.
    sequence s_req_ack;
        req ##1 ack;
    endsequence
    a_ack_follows: assert property (req |-> s_req_ack)
        else $error("ack missing");
    a_ack_cause: assert property (ack |-> $past(req))
        else $error("ack without request");
    a_req_gap: assert property (req |=> !req [*2])
        else $error("requests too close");
    a_req_held: assert property (ack |-> $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed early");
    a_cfg_zero: assert property (req && we && addr == `AFE_A_CFG |-> (wdata & ~`AFE_CFG_MASK) == 9'h000)
        else $error("config reserved bits set");
    a_mux_zero: assert property (req && we && addr == `AFE_A_MUX |-> (wdata & ~`AFE_MUX_MASK) == 9'h000)
        else $error("order reserved bits set");
    a_gain_zero: assert property (req && we && addr inside {[3'h2:3'h4]} |-> wdata[8:6] == 3'h0)
        else $error("gain reserved bits set");
    a_rdata_hold: assert property ($changed(rdata) |-> ack)
        else $error("read data moved");
    a_sample_pulse: assert property (data_sample_clock |=> !data_sample_clock)
        else $error("sample pulse too long");
endmodule
`default_nettype wire

//--- verification/scanner_afe_config_registers_tb.sv
`include "afe_defines.svh"
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module scanner_afe_config_registers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, erv, seq_on, cprev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv, seed;
    logic full_scale_4v, int_ref_en, channel_count_select, double_sampling_mode;
    logic clamp_4v, sleep_select, offset_neg;
    logic [5:0] gain_amplifier;
    logic [7:0] offset_mag;
    logic [1:0] sn;
    afe_pkg::afe_chan_e active_channel, pos_q, xact_q;
    afe_pkg::afe_word_t dv, tcfg, tmux;
    afe_pkg::afe_word_t sh [8];
    int err_count, n_checks;
    afe_link_if link_if ();
    afe_dev afe_dev_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link_if.dev),
        .full_scale_4v(full_scale_4v), .int_ref_en(int_ref_en),
        .channel_count_select(channel_count_select), .double_sampling_mode(double_sampling_mode),
        .clamp_4v(clamp_4v), .sleep_select(sleep_select), .active_channel(active_channel),
        .gain_amplifier(gain_amplifier), .offset_mag(offset_mag), .offset_neg(offset_neg));
    afe_host #(.CONV_DIV(4)) afe_host_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link_if.host));
    afe_link_chk chk_inst (.core_clk(core_clk), .rst_n(rst_n), .req(link_if.req),
        .we(link_if.we), .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack),
        .rdata(link_if.rdata), .data_sample_clock(link_if.data_sample_clock),
        .converter_clock(link_if.converter_clock));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic afe_pkg::afe_word_t msk(input int a);
        return a == 0 ? `AFE_CFG_MASK : a == 1 ? `AFE_MUX_MASK : a < 5 ? `AFE_GAIN_MASK : `AFE_OFFS_MASK;
    endfunction
    function automatic afe_pkg::afe_chan_e sel(input afe_pkg::afe_word_t m);
        return m[6] ? afe_pkg::CH_RED : m[5] ? afe_pkg::CH_GREEN : m[4] ? afe_pkg::CH_BLUE : afe_pkg::CH_RED;
    endfunction
    function automatic afe_pkg::afe_chan_e nxt(input afe_pkg::afe_chan_e c, input logic f);
        if (c == afe_pkg::CH_GREEN) return f ? afe_pkg::CH_BLUE : afe_pkg::CH_RED;
        if (c == afe_pkg::CH_RED) return f ? afe_pkg::CH_GREEN : afe_pkg::CH_BLUE;
        return f ? afe_pkg::CH_RED : afe_pkg::CH_GREEN;
    endfunction
    // One APB transfer; the bus idles one cycle afterwards.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A slave that never answers ends the run as a failure.
        if (pready !== 1'b1) begin
            $display("FAIL t=%0t no pready", $time);
            err_count++;
            give_verdict();
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // One device register access through the controller, then done is cleared.
    task automatic dev_acc(input logic rd, input logic [2:0] a, input afe_pkg::afe_word_t d);
        int n;
        n = 0;
        apb(1'b1, `AFE_H_CMD, {15'h0, rd, 1'b0, a, 3'h0, d});
        do begin
            apb(1'b0, `AFE_H_STATUS, 32'h0);
            n++;
        end while (rdv[`AFE_ST_DONE] !== 1'b1 && n < 20);
        // A link transfer that never completes ends the run as a failure.
        if (rdv[`AFE_ST_DONE] !== 1'b1) begin
            $display("FAIL t=%0t no done", $time);
            err_count++;
            give_verdict();
        end
        dv = rdv[24:16];
        apb(1'b1, `AFE_H_STATUS, 32'h2);
    endtask
    // Reads every device register back against the shadow copy.
    task automatic rd_all;
        for (int i = 0; i < 8; i++) begin
            dev_acc(1'b1, i[2:0], 9'h000);
            `CHK(dv, sh[i])
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Reference channel position, compared two edges after the device position.
    always @(posedge core_clk) begin
        cprev <= link_if.converter_clock;
        sn <= {sn[0], seq_on && (sn[0] || link_if.data_sample_clock)};
        if (!tcfg[5]) pos_q <= sel(tmux);
        else if (link_if.data_sample_clock) pos_q <= tmux[7] ? afe_pkg::CH_RED : afe_pkg::CH_BLUE;
        else if (cprev && !link_if.converter_clock && !tcfg[2]) pos_q <= nxt(pos_q, tmux[7]);
        xact_q <= pos_q;
        if (seq_on && sn[1]) `CHK(active_channel, xact_q)
    end
    // Clock.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Watchdog.
    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        give_verdict();
    end
    // Main sequence.
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, seq_on, sn} = '0;
        seed = 32'h161f;
        tcfg = `AFE_CFG_RST;
        tmux = `AFE_MUX_RST;
        foreach (sh[i]) sh[i] = i == 0 ? `AFE_CFG_RST : i == 1 ? `AFE_MUX_RST : 9'h000;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        `CHK({full_scale_4v, int_ref_en, channel_count_select, double_sampling_mode, clamp_4v, sleep_select}, 6'h3e)
        rd_all();
        $display("test reset done");
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < 8; i++) begin
                seed = lfsr(seed);
                dev_acc(1'b0, i[2:0], seed[8:0]);
                sh[i] = seed[8:0] & msk(i);
            end
            rd_all();
            `CHK({full_scale_4v, int_ref_en, channel_count_select, double_sampling_mode, clamp_4v, sleep_select}, sh[0][7:2])
        end
        $display("test random done");
        sh[0] = sh[0] | 9'h004;
        dev_acc(1'b0, 3'h0, sh[0]);
        `CHK(sleep_select, 1'b1)
        rd_all();
        sh[0] = sh[0] & 9'h1fb;
        dev_acc(1'b0, 3'h0, sh[0]);
        rd_all();
        $display("test sleep done");
        apb(1'b1, 12'h00c, 32'hffffffff);
        `CHK(erv, 1'b1)
        apb(1'b0, `AFE_H_CMD, 32'h0);
        `CHK(rdv, 32'h0)
        $display("test apb done");
        // Reset in mid-run brings every register back to its default.
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        foreach (sh[i]) sh[i] = i == 0 ? `AFE_CFG_RST : i == 1 ? `AFE_MUX_RST : 9'h000;
        `CHK({full_scale_4v, int_ref_en, channel_count_select, double_sampling_mode, clamp_4v, sleep_select}, 6'h3e)
        rd_all();
        $display("test second reset done");
        sh[5] = 9'h100;
        dev_acc(1'b0, 3'h5, sh[5]);
        apb(1'b1, `AFE_H_RUN, 32'h1);
        for (int m = 0; m < 5; m++) begin
            seq_on <= 1'b0;
            tmux = m == 0 ? 9'h080 : m == 1 ? 9'h000 : 9'h040 >> (m - 2);
            tcfg = m < 2 ? 9'h0f8 : 9'h0d8;
            dev_acc(1'b0, 3'h1, tmux);
            dev_acc(1'b0, 3'h0, tcfg);
            seq_on <= 1'b1;
            repeat (80) @(posedge core_clk);
            `CHK(sn[1], 1'b1)
            if (m > 1) begin
                `CHK(gain_amplifier, sh[m][5:0])
                `CHK(offset_mag, sh[m + 3][7:0])
                `CHK(offset_neg, sh[m + 3][8] & (|sh[m + 3][7:0]))
            end
        end
        seq_on <= 1'b0;
        $display("test sequence done");
        give_verdict();
    end
endmodule
`default_nettype wire
